// ===== test/bfc_flash_model.sv
// behavioural bottom-boot flash answering the controller's strobes
`timescale 1ns/1ps
module bfc_flash_model
    import bfc_pkg::*;
#(
    parameter int         BUSY_NS     = 3000,
    parameter int         RST_BUSY_NS = 400,
    parameter logic [7:0] MFR_CODE    = 8'ha5, // arbitrary value
    parameter logic [7:0] DEV_CODE    = 8'h3c  // arbitrary value
) (
    input  wire logic [18:0]        addr_i,
    input  wire bfc_pkg::bfc_data_t dq_i,
    input  wire logic               ce_n_i,
    input  wire logic               oe_n_i,
    input  wire logic               we_n_i,
    input  wire logic               word_i,
    input  wire logic               rst_n_i,
    output bfc_pkg::bfc_data_t      dq_o,
    output logic                    rb_n_o
);
    import bfc_pkg::*;
    logic [15:0] mem [int];
    logic [19:0] la, ra;
    logic [7:0]  cmd, op;
    bfc_data_t   v;
    int          step;
    logic        busy, susp, as_mode, tog;
    realtime     t_end, rem;
    wire         wr = !ce_n_i && !we_n_i;
    initial begin
        {step, busy, susp, as_mode, tog, dq_o} = '0;
    end
    assign rb_n_o = !busy || susp;
    always @(posedge wr) la = word_i ? {1'b0, addr_i} : {addr_i, dq_i[15]};
    // unlock addresses are not checked, only the coded data
    always @(negedge wr) begin
        cmd = dq_i[7:0];
        case (step)
            0: step = (cmd == 8'h11) ? 1 : 0;
            1: step = (cmd == 8'h22) ? 2 : 0;
            2: begin
                op = cmd;
                step = 0;
                if (cmd == 8'h37 && busy) begin
                    susp = 1'b1;
                    rem = t_end - $realtime;
                end else if (cmd == 8'h38 && susp) begin
                    susp = 1'b0;
                    t_end = $realtime + rem;
                end else if (cmd == 8'h31 || cmd == 8'h32) as_mode = cmd[1];
                else if ((cmd == 8'h33 || cmd == 8'h34) && !(busy && !susp)) step = 3;
            end
            3: begin
                step = (op == 8'h34 && cmd == 8'h11) ? 4 : 0;
                if (op == 8'h33) mem[la] = dq_i;
                if (op == 8'h33 && !susp) begin
                    busy = 1'b1;
                    t_end = $realtime + BUSY_NS;
                end
            end
            4: step = (cmd == 8'h22) ? 5 : 0;
            default: begin
                step = 0;
                // block boundaries are not modelled: any erase blanks the array
                if (cmd == 8'h35 || cmd == 8'h36) begin
                    mem.delete();
                    busy = 1'b1;
                    t_end = $realtime + BUSY_NS;
                end
            end
        endcase
    end
    always #10 if (busy && !susp && rst_n_i && $realtime >= t_end) busy = 1'b0;
    always @(negedge rst_n_i) begin
        step = 0;
        as_mode = 1'b0;
        susp = 1'b0;
        if (busy) t_end = $realtime + RST_BUSY_NS;
    end
    always #10 begin
        tog = ~tog;
        ra = word_i ? {1'b0, addr_i} : {addr_i, dq_i[15]};
        if (ce_n_i || oe_n_i || !rst_n_i) v = ~dq_o;
        else if (busy && !susp) v = {9'h000, tog, 3'b001, tog, 2'b00};
        else if (as_mode) v = {8'h00, addr_i[1] ? 8'h00 : (addr_i[0] ? DEV_CODE : MFR_CODE)};
        else v = mem.exists(ra) ? mem[ra] : 16'hffff;
        if (!word_i) v[15:8] = ~dq_o[15:8];
        dq_o = v;
    end
endmodule

// ===== test/boot_flash_command_bus_tb_top.sv
// self-checking bench: wishbone driver, flash model, random program and readback
`timescale 1ns/1ps
`include "bfc_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module boot_flash_command_bus_tb_top;
    import bfc_pkg::*;
    logic        clk_i, nrst_i, cyc, stb, we, ack, rb_n;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q, st, lf;
    logic [19:0] a;
    logic [15:0] d;
    logic [18:0] f_addr;
    bfc_data_t   c_dq, f_dq, bus;
    logic        lo_oe, hi_oe, d15_oe, ce_n, oe_n, we_n, word, rpn, hvr, hva9;
    int          err_count, cmp_count, rst_low, rst_max;
    logic [19:0] bnd [5] = '{20'h01fff, 20'h02000, 20'h03000, 20'h04000, 20'h7ffff};
    assign bus = {d15_oe ? c_dq[15] : f_dq[15], hi_oe ? c_dq[14:8] : f_dq[14:8],
                  lo_oe ? c_dq[7:0] : f_dq[7:0]};
    bfc_ctrl #(.RST_PULSE_CYC(4), .RST_REC_CYC(3)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .addr_o(f_addr), .dq_o(c_dq),
        .dq_i(bus), .dq_lo_oe_o(lo_oe), .dq_hi_oe_o(hi_oe), .dq15_oe_o(d15_oe), .ce_n_o(ce_n),
        .oe_n_o(oe_n), .we_n_o(we_n), .word_mode_o(word), .reset_unprotect_n_o(rpn),
        .hv_reset_o(hvr), .hv_mode_addr_line_o(hva9), .ready_busy_n_i(rb_n));
    bfc_flash_model u_flash (.addr_i(f_addr), .dq_i(bus), .ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .word_i(word), .rst_n_i(rpn), .dq_o(f_dq), .rb_n_o(rb_n));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        rst_low <= rpn ? 0 : rst_low + 1;
        if (rpn && rst_low != 0) rst_max <= rst_low;
        if (nrst_i && !word) `CHK("hi_oe", 1'b0, hi_oe)
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [4:0] blk_of(input logic [19:0] b);
        if (b < 20'h04000) return 5'd0;
        if (b < 20'h06000) return 5'd1;
        if (b < 20'h08000) return 5'd2;
        return (b < 20'h10000) ? 5'd3 : 5'(b[19:16] + 3);
    endfunction
    task automatic wb(input logic [7:0] ad, input logic w, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, ad, dt};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) err_count++;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic go(input logic [7:0] ctl, input logic [19:0] ga, input logic [15:0] gd,
                      input bit w);
        int n;
        n = 0;
        wb(`BFC_OFF_ADDR, 1'b1, {12'h0, ga});
        wb(`BFC_OFF_WDATA, 1'b1, {16'h0, gd});
        wb(`BFC_OFF_CTRL, 1'b1, {24'h0, ctl});
        while (w && n < 400) begin
            wb(`BFC_OFF_STATUS, 1'b0, 32'h0);
            n++;
            if (q[2] === 1'b1) break;
        end
        st = q;
        if (w) `CHK("done", 1'b1, st[2])
        if (w) wb(`BFC_OFF_STATUS, 1'b1, 32'hc);
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            wb(`BFC_OFF_STATUS, 1'b0, 32'h0);
            n++;
        end while (q[1] !== 1'b1 && n < 400);
        `CHK("ready", 1'b1, q[1])
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #800000;
        err_count++;
        finish_test();
    end
    initial begin
        {cyc, stb, we, adr, wdat, nrst_i, err_count, cmp_count, rst_low, rst_max} = '0;
        sel = 4'hf;
        lf = 32'h4cf1;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        wb(`BFC_OFF_CTRL, 1'b0, 32'h0);
        `CHK("ctrl", 32'h10, q)
        wb(`BFC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("status", 32'h2, q)
        wb(8'h20, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < 7; i++) begin
            lf = nxt(lf);
            a = (i < 5) ? bnd[i] : {1'b0, lf[18:0]};
            d = lf[31:16];
            go(8'h1a, a, d, 1'b1);
            wait_rdy();
            `CHK("block", blk_of({a[18:0], 1'b0}), q[12:8])
            go(8'h18, a, 16'h0, 1'b1);
            wb(`BFC_OFF_RDATA, 1'b0, 32'h0);
            `CHK("rdata", {16'h0, d}, q)
        end
        go(8'h19, 20'h0, 16'h0, 1'b1);
        wb(`BFC_OFF_RDATA, 1'b0, 32'h0);
        `CHK("mfr", 32'ha5, q)
        go(8'h09, 20'h3, 16'h0, 1'b1);
        wb(`BFC_OFF_RDATA, 1'b0, 32'h0);
        `CHK("dev_byte", 32'h3c, q)
        go(8'h1b, a, 16'h0, 1'b1);
        go(8'h1a, 20'h100, 16'h1234, 1'b0);
        wb(`BFC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("refused", 2'b10, q[3:2])
        wb(`BFC_OFF_STATUS, 1'b1, 32'hc);
        go(8'h1f, a, 16'h0, 1'b1);
        wb(`BFC_OFF_RDATA, 1'b0, 32'h0);
        `CHK("poll", 2'b01, {q[7], q[3]})
        wb(`BFC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("busy_err", 2'b00, {q[4], q[1]})
        go(8'h1d, a, 16'h0, 1'b1);
        wait_rdy();
        go(8'h1e, a, 16'h0, 1'b1);
        wb(`BFC_OFF_STATUS, 1'b0, 32'h0);
        `CHK("resumed", 1'b0, q[1])
        wait_rdy();
        go(8'h18, a, 16'h0, 1'b1);
        wb(`BFC_OFF_RDATA, 1'b0, 32'h0);
        `CHK("erased", 32'hffff, q)
        go(8'h1c, 20'h0, 16'h0, 1'b1);
        wait_rdy();
        go(8'h1a, 20'h40, 16'h55aa, 1'b1);
        go(8'h30, 20'h0, 16'h0, 1'b1);
        `CHK("rst_len", 4, rst_max)
        `CHK("rst_rdy", 1'b1, st[1])
        // neighbouring bytes only differ in the lsb carried on the top data pin
        go(8'h0a, 20'h41, 16'h00c3, 1'b1);
        wait_rdy();
        go(8'h0a, 20'h40, 16'h003c, 1'b1);
        wait_rdy();
        go(8'h08, 20'h41, 16'h0, 1'b1);
        wb(`BFC_OFF_RDATA, 1'b0, 32'h0);
        `CHK("byte_lsb", 32'hc3, q)
        wb(`BFC_OFF_CTRL, 1'b1, 32'hd0);
        wb(`BFC_OFF_CTRL, 1'b0, 32'h0);
        `CHK("hv", 35'h3_0000_00d0, {hvr, hva9, q})
        wb(`BFC_OFF_CTRL, 1'b1, 32'h10);
        finish_test();
    end
endmodule

// ===== verilog/bfc_ctrl.sv
// wishbone-controlled host for a bottom-boot parallel nor flash
// How it works
// - every instruction except raw read opens with two unlock writes; raw read starts at the fourth step
// - third write is setup; reads follow it
// - program address and data on fourth write
// - erase: unlock again, confirm on sixth
// - reset pulse minimum, then recovery wait
`timescale 1ns/1ps
`include "bfc_defs.svh"
module bfc_ctrl #(
    parameter int        RST_PULSE_CYC = (`BFC_RST_PULSE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS,
    parameter int        RST_REC_CYC   = (`BFC_RST_REC_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS,
    parameter bfc_pkg::bfc_addr_t UNLK_A1 = 20'h00001,
    parameter bfc_pkg::bfc_addr_t UNLK_A2 = 20'h00002,
    parameter bfc_pkg::bfc_addr_t CMD_A   = 20'h00001,
    parameter logic [7:0] UNLK_D1      = 8'h11,
    parameter logic [7:0] UNLK_D2      = 8'h22,
    parameter logic [7:0] CMD_READ     = 8'h31,
    parameter logic [7:0] CMD_AUTOSEL  = 8'h32,
    parameter logic [7:0] CMD_PROG     = 8'h33,
    parameter logic [7:0] CMD_ERASE    = 8'h34,
    parameter logic [7:0] CMD_BLK_CONF = 8'h35,
    parameter logic [7:0] CMD_CHP_CONF = 8'h36,
    parameter logic [7:0] CMD_SUSPEND  = 8'h37,
    parameter logic [7:0] CMD_RESUME   = 8'h38
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [18:0]      addr_o,
    output bfc_pkg::bfc_data_t dq_o,
    input  wire bfc_pkg::bfc_data_t dq_i,
    output logic             dq_lo_oe_o,
    output logic             dq_hi_oe_o,
    output logic             dq15_oe_o,
    output logic             ce_n_o,
    output logic             oe_n_o,
    output logic             we_n_o,
    output logic             word_mode_o,
    output logic             reset_unprotect_n_o,
    output logic             hv_reset_o,
    output logic             hv_mode_addr_line_o,
    input  wire logic        ready_busy_n_i
);
    import bfc_pkg::*;

    localparam int SETUP_CYC = (`BFC_SETUP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
    localparam int PULSE_CYC = (`BFC_PULSE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
    localparam int HOLD_CYC  = (`BFC_HOLD_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;

    bfc_state_e state_q;
    bfc_op_e    op_q;
    logic [2:0] step_q;
    logic [31:0] tmr_q;
    bfc_addr_t  addr_q;
    bfc_data_t  wdata_q;
    logic       word_q, hvrp_q, hva9_q, done_q, refused_q, wb_ack_q;
    logic [1:0] rb_sync_q;
    bfc_data_t  dq_s1_q, dq_s2_q;
    logic [31:0] rd_d;
    bfc_addr_t  cyc_addr;
    logic [7:0] cyc_data;
    logic       cyc_read, last_step, start, sdone, drive;
    bfc_data_t  srdata, rdata;
    logic [4:0] blk_idx;
    logic       req, wr_ctrl, go, op_pe, rb_ready;

    // erase and program are refused while the flash reports busy
    assign rb_ready = rb_sync_q[1];
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wr_ctrl  = req && wb_we_i && wb_adr_i == `BFC_OFF_CTRL && wb_sel_i[0];
    assign go       = wr_ctrl && wb_dat_i[`BFC_CTRL_GO];
    assign op_pe    = wb_dat_i[2:0] inside {OP_PROGRAM, OP_BLK_ERASE, OP_CHIP_ERASE};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rb_sync_q <= 2'b00;
            dq_s1_q   <= 16'h0000;
            dq_s2_q   <= 16'h0000;
        end else begin
            rb_sync_q <= {rb_sync_q[0], ready_busy_n_i};
            dq_s1_q   <= dq_i;
            dq_s2_q   <= dq_s1_q;
        end
    end

    // bottom-boot block index of the programmed address
    always_comb begin
        logic [19:0] ba;
        ba = word_q ? {addr_q[18:0], 1'b0} : addr_q;
        if (ba[19:16] != 4'h0)          blk_idx = 5'(ba[19:16]) + 5'd3;
        else if (ba[15])                blk_idx = 5'd3;
        else if (ba[14:13] == 2'b11)    blk_idx = 5'd2;
        else if (ba[14:13] == 2'b10)    blk_idx = 5'd1;
        else                            blk_idx = 5'd0;
    end

    // the command cycle presented at each step of an instruction
    always_comb begin
        cyc_addr  = CMD_A;
        cyc_data  = 8'h00;
        cyc_read  = 1'b0;
        last_step = 1'b0;
        unique case (step_q)
            3'd0: begin
                cyc_addr = UNLK_A1;
                cyc_data = UNLK_D1;
            end
            3'd1: begin
                cyc_addr = UNLK_A2;
                cyc_data = UNLK_D2;
            end
            3'd2: begin
                unique case (op_q)
                    OP_READ_ARRAY: cyc_data = CMD_READ;
                    OP_AUTO_SEL:   cyc_data = CMD_AUTOSEL;
                    OP_PROGRAM:    cyc_data = CMD_PROG;
                    OP_SUSPEND:    cyc_data = CMD_SUSPEND;
                    OP_RESUME:     cyc_data = CMD_RESUME;
                    default:       cyc_data = CMD_ERASE;
                endcase
                last_step = op_q inside {OP_SUSPEND, OP_RESUME};
            end
            3'd3: begin
                if (op_q inside {OP_BLK_ERASE, OP_CHIP_ERASE}) begin
                    cyc_addr = UNLK_A1;
                    cyc_data = UNLK_D1;
                end else begin
                    cyc_addr  = addr_q;
                    cyc_data  = wdata_q[7:0];
                    cyc_read  = op_q != OP_PROGRAM;
                    last_step = 1'b1;
                end
            end
            3'd4: begin
                cyc_addr = UNLK_A2;
                cyc_data = UNLK_D2;
            end
            default: begin
                cyc_addr  = (op_q == OP_BLK_ERASE) ? addr_q : CMD_A;
                cyc_data  = (op_q == OP_BLK_ERASE) ? CMD_BLK_CONF : CMD_CHP_CONF;
                last_step = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            op_q    <= OP_READ_ARRAY;
            step_q  <= 3'd0;
            tmr_q   <= 32'h0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (wr_ctrl && wb_dat_i[`BFC_CTRL_RST]) begin
                        state_q <= S_RST_LOW;
                        tmr_q   <= 32'(RST_PULSE_CYC - 1);
                    end else if (go && !(op_pe && !rb_ready)) begin
                        state_q <= S_ISSUE;
                        op_q    <= bfc_op_e'(wb_dat_i[2:0]);
                        step_q  <= (wb_dat_i[2:0] == OP_RAW_READ) ? 3'd3 : 3'd0;
                    end
                end
                S_ISSUE: state_q <= S_WAIT;
                S_WAIT: begin
                    if (sdone) begin
                        state_q <= last_step ? S_IDLE : S_ISSUE;
                        step_q  <= step_q + 3'd1;
                    end
                end
                S_RST_LOW: begin
                    if (tmr_q == 32'h0) begin
                        state_q <= S_RST_REC;
                        tmr_q   <= 32'(RST_REC_CYC - 1);
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                S_RST_REC: begin
                    if (tmr_q == 32'h0) begin
                        state_q <= S_RST_RB;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                S_RST_RB: begin
                    // an interrupted operation keeps ready low until its reset ends
                    if (rb_ready) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    assign start = (state_q == S_ISSUE);

    bfc_strobe #(
        .SETUP_CYC (SETUP_CYC),
        .PULSE_CYC (PULSE_CYC),
        .HOLD_CYC  (HOLD_CYC)
    ) u_strobe (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .start_i   (start),
        .write_i   (!cyc_read),
        .dq_sync_i (dq_s2_q),
        .ce_n_o    (ce_n_o),
        .oe_n_o    (oe_n_o),
        .we_n_o    (we_n_o),
        .drive_o   (drive),
        .rdata_o   (srdata),
        .done_o    (sdone)
    );

    // byte mode: upper lanes idle, top pin carries the address lsb
    assign addr_o      = word_q ? cyc_addr[18:0] : cyc_addr[19:1];
    assign dq_lo_oe_o  = drive;
    assign dq_hi_oe_o  = drive && word_q;
    assign dq15_oe_o   = !word_q || (drive && word_q);
    assign dq_o        = !word_q ? {cyc_addr[0], 7'h00, cyc_data} :
                         (op_q == OP_PROGRAM && step_q == 3'd3) ? wdata_q :
                         {8'h00, cyc_data};
    assign rdata       = word_q ? srdata : {8'h00, srdata[7:0]};
    assign word_mode_o = word_q;
    assign reset_unprotect_n_o = (state_q != S_RST_LOW);
    assign hv_reset_o  = hvrp_q && (state_q != S_RST_LOW);
    assign hv_mode_addr_line_o = hva9_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            addr_q  <= 20'h00000;
            wdata_q <= 16'h0000;
            word_q  <= `BFC_WORD_RST;
            hvrp_q  <= 1'b0;
            hva9_q  <= 1'b0;
        end else if (req && wb_we_i) begin
            if (wr_ctrl) begin
                word_q <= wb_dat_i[`BFC_CTRL_WORD];
                hvrp_q <= wb_dat_i[`BFC_CTRL_HVRP];
                hva9_q <= wb_dat_i[`BFC_CTRL_HVA9];
            end
            if (wb_adr_i == `BFC_OFF_ADDR) begin
                if (wb_sel_i[0]) addr_q[7:0]   <= wb_dat_i[7:0];
                if (wb_sel_i[1]) addr_q[15:8]  <= wb_dat_i[15:8];
                if (wb_sel_i[2]) addr_q[19:16] <= wb_dat_i[19:16];
            end
            if (wb_adr_i == `BFC_OFF_WDATA) begin
                if (wb_sel_i[0]) wdata_q[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) wdata_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    logic done_set, clr_done, clr_ref;
    assign done_set = (state_q == S_WAIT && sdone && last_step) ||
                      (state_q == S_RST_RB && rb_ready);
    assign clr_done = req && wb_we_i && wb_adr_i == `BFC_OFF_STATUS && wb_sel_i[0] &&
                      wb_dat_i[`BFC_ST_DONE];
    assign clr_ref  = req && wb_we_i && wb_adr_i == `BFC_OFF_STATUS && wb_sel_i[0] &&
                      wb_dat_i[`BFC_ST_REFUSED];

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            done_q    <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            done_q    <= done_set || (done_q && !clr_done);
            refused_q <= (go && state_q == S_IDLE && op_pe && !rb_ready) ||
                         (go && state_q != S_IDLE) || (refused_q && !clr_ref);
        end
    end

    always_comb begin
        rd_d = 32'h0;
        unique case (wb_adr_i)
            `BFC_OFF_CTRL:   rd_d = {24'h0, hva9_q, hvrp_q, 1'b0, word_q, 1'b0, op_q};
            `BFC_OFF_ADDR:   rd_d = {12'h0, addr_q};
            `BFC_OFF_WDATA:  rd_d = {16'h0, wdata_q};
            `BFC_OFF_RDATA:  rd_d = {16'h0, rdata};
            `BFC_OFF_STATUS: rd_d = {19'h0, blk_idx, 3'h0, rdata[5], refused_q, done_q,
                                     rb_ready, state_q != S_IDLE};
            default:         rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_q <= req;
            if (req) begin
                wb_dat_o <= rd_d;
            end
        end
    end
    assign wb_ack_o = wb_ack_q;

    logic [31:0] low_cnt_q;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            low_cnt_q <= 32'h0;
        end else begin
            low_cnt_q <= reset_unprotect_n_o ? 32'h0 : low_cnt_q + 32'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_step(logic [2:0] n);
        start && step_q == n;
    endsequence

    unlock_first_a: assert property (s_step(3'd0) |-> cyc_data == UNLK_D1)
        else $error("first cycle is not the unlock code");
    unlock_second_a: assert property (s_step(3'd1) |->
        cyc_data == UNLK_D2 && cyc_addr == UNLK_A2)
        else $error("second cycle is not the unlock code");
    prog_setup_a: assert property (s_step(3'd2) ##0 (op_q == OP_PROGRAM) |->
        cyc_data == CMD_PROG)
        else $error("program setup code wrong");
    prog_data_a: assert property (s_step(3'd3) ##0 (op_q == OP_PROGRAM) |->
        dq_o[7:0] == wdata_q[7:0] && (!word_q || dq_o == wdata_q))
        else $error("program data not on fourth cycle");
    erase_confirm_a: assert property (s_step(3'd5) ##0 (op_q == OP_BLK_ERASE) |->
        cyc_data == CMD_BLK_CONF && cyc_addr == addr_q)
        else $error("block erase confirm wrong");
    busy_refuse_a: assert property (go && !wb_dat_i[`BFC_CTRL_RST] && state_q == S_IDLE &&
        op_pe && !rb_ready |=> state_q == S_IDLE && refused_q)
        else $error("program or erase started while busy");
    reset_width_a: assert property ($rose(reset_unprotect_n_o) |->
        $past(low_cnt_q) >= 32'(RST_PULSE_CYC - 1))
        else $error("reset pulse too short");
    byte_lanes_a: assert property (!word_q |-> !dq_hi_oe_o && dq15_oe_o)
        else $error("byte mode lane use wrong");
    cmd_upper_a: assert property (dq_hi_oe_o && !(op_q == OP_PROGRAM && step_q == 3'd3) |->
        dq_o[15:8] == 8'h00)
        else $error("command upper byte not zero");
endmodule

// ===== verilog/bfc_defs.svh
// register offsets, field positions, reset values and timing figures of the flash controller
`ifndef BFC_DEFS_SVH
`define BFC_DEFS_SVH

`define BFC_OFF_CTRL    8'h00
`define BFC_OFF_ADDR    8'h04
`define BFC_OFF_WDATA   8'h08
`define BFC_OFF_RDATA   8'h0c
`define BFC_OFF_STATUS  8'h10

`define BFC_CTRL_OP_LSB 0
`define BFC_CTRL_GO     3
`define BFC_CTRL_WORD   4
`define BFC_CTRL_RST    5
`define BFC_CTRL_HVRP   6
`define BFC_CTRL_HVA9   7

`define BFC_ST_BUSY     0
`define BFC_ST_READY    1
`define BFC_ST_DONE     2
`define BFC_ST_REFUSED  3
`define BFC_ST_ERROR    4
`define BFC_ST_BLK_LSB  8

`define BFC_WORD_RST    1'b1

`define BFC_CLK_NS        10
`define BFC_SETUP_NS      20
`define BFC_PULSE_NS      60
`define BFC_HOLD_NS       20
`define BFC_RST_PULSE_NS  500
`define BFC_RST_REC_NS    1000

`endif

// ===== verilog/bfc_pkg.sv
// types shared by the flash controller modules
package bfc_pkg;
    typedef logic [19:0] bfc_addr_t;
    typedef logic [15:0] bfc_data_t;
    typedef enum logic [2:0] {
        OP_READ_ARRAY, OP_AUTO_SEL, OP_PROGRAM, OP_BLK_ERASE,
        OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_RAW_READ
    } bfc_op_e;
    typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD} bfc_phase_e;
    typedef enum logic [2:0] {
        S_IDLE, S_ISSUE, S_WAIT, S_RST_LOW, S_RST_REC, S_RST_RB
    } bfc_state_e;
endpackage

// ===== verilog/bfc_strobe.sv
// one asynchronous bus cycle on the flash strobes
`timescale 1ns/1ps
module bfc_strobe #(
    parameter int SETUP_CYC = 2,
    parameter int PULSE_CYC = 6,
    parameter int HOLD_CYC  = 2
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             start_i,
    input  wire logic             write_i,
    input  wire bfc_pkg::bfc_data_t dq_sync_i,
    output logic                  ce_n_o,
    output logic                  oe_n_o,
    output logic                  we_n_o,
    output logic                  drive_o,
    output bfc_pkg::bfc_data_t    rdata_o,
    output logic                  done_o
);
    import bfc_pkg::*;

    bfc_phase_e ph_q;
    logic [7:0] cnt_q;
    logic       wr_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ph_q  <= PH_IDLE;
            cnt_q <= 8'h00;
            wr_q  <= 1'b0;
        end else begin
            unique case (ph_q)
                PH_IDLE: begin
                    if (start_i) begin
                        ph_q  <= PH_SETUP;
                        cnt_q <= 8'(SETUP_CYC - 1);
                        wr_q  <= write_i;
                    end
                end
                PH_SETUP: begin
                    if (cnt_q == 8'h00) begin
                        ph_q  <= PH_PULSE;
                        // reads stretch by the two synchroniser stages
                        cnt_q <= wr_q ? 8'(PULSE_CYC - 1) : 8'(PULSE_CYC + 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_PULSE: begin
                    if (cnt_q == 8'h00) begin
                        ph_q  <= PH_HOLD;
                        cnt_q <= 8'(HOLD_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_HOLD: begin
                    if (cnt_q == 8'h00) begin
                        ph_q <= PH_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 16'h0000;
        end else if (ph_q == PH_PULSE && !wr_q && cnt_q == 8'h00) begin
            rdata_o <= dq_sync_i;
        end
    end

    // select falls before write strobe and stays low past its rise
    assign ce_n_o  = (ph_q == PH_IDLE);
    assign we_n_o  = !(ph_q == PH_PULSE && wr_q);
    assign oe_n_o  = !(ph_q == PH_PULSE && !wr_q);
    assign drive_o = wr_q && (ph_q != PH_IDLE);
    assign done_o  = (ph_q == PH_HOLD) && (cnt_q == 8'h00);

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_sel_low;
        !ce_n_o;
    endsequence

    addr_latch_order_a: assert property ($fell(we_n_o) |-> $past(!ce_n_o) and s_sel_low)
        else $error("write strobe fell without select already low");
    data_latch_order_a: assert property ($rose(we_n_o) |-> s_sel_low)
        else $error("select rose before write strobe");
    no_contention_a: assert property (!oe_n_o |-> !drive_o && !ce_n_o)
        else $error("controller drives data while flash outputs enabled");
endmodule
